// ---- hw/udc_counter.sv ----
// presettable 4-bit up/down counter, decade or binary build, axi4-lite
// assumes all pins synchronous to aclk and a single clock domain
//
// Function
// R1: four-bit up/down synchronous counter, decade (bcd) or binary build.
// R2: binary build acts the same but wraps modulo 16 instead of 10.
// R3: every counter state change happens on the rising clock edge only.
// R4: outputs can be preset to any value through the four data inputs.
// R5: load enable low copies data inputs at next edge and stops counting.
// R6: parallel load happens whatever the two count enables show.
// R7: load takes precedence over every other operation on that edge.
// R8: count only with load high and both enables low, else hold.
// R9: both active-low count enables must be low; either high freezes.
// R10: enabled with direction high, increment by one each rising edge.
// R11: enabled with direction low, decrement by one each rising edge.
// R12: terminal count low at zero counting down or top counting up.
// R13: trickle enable gates terminal count combinationally; high forces high.
// R14: terminal count ignores the parallel count enable level.
// R15: binary build decodes up at all ones, down at all zeros.
// R16: decade build decodes up at nine, down at all zeros.
// R17: decade terminal count may also assert in states 11, 13, 15.
// R18: decade build returns from unused states within two count steps.
// R19: terminal count pulse spans about the high half of bit zero.
// R20: cascaded stages feed terminal count into the next stage enables.
// R21: terminal count must not be used as a clock; it may glitch.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module udc_counter
  import udc_pkg::*;
#(
  parameter int COUNT_W = udc_pkg::UDC_COUNT_W,
  parameter bit DECADE = 1'b1
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // counter controls
  input wire logic load_enable_n,
  input wire logic parallel_count_enable_n,
  input wire logic trickle_count_enable_n,
  input wire logic count_up,
  input wire logic [3:0] preset_value,
  // counter results
  output logic [3:0] count_value,
  output logic terminal_count_n
);
  import udc_pkg::*;

  // only the documented four-bit counter is served
  initial
  begin
    if (COUNT_W != 4)
    begin
      $error("udc_counter: COUNT_W must be 4");
    end
  end

  udc_state_s state_reg;
  udc_state_s state_next;
  logic run_now;
  logic tc_up_hit;
  logic tc_down_hit;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_ctrl;

  // counting is allowed only with load high and both enables low
  // R8: count condition
  // R9: both enables
  assign run_now = load_enable_n & ~parallel_count_enable_n
                   & ~trickle_count_enable_n & state_reg.run;

  // terminal state decode; decade up uses bits 0 and 3 only
  // R15: binary decode
  // R16: decade decode
  // R17: unused states hit
  assign tc_up_hit = DECADE ? (state_reg.count[0] & state_reg.count[3])
                            : (state_reg.count == UDC_BINARY_TOP);
  assign tc_down_hit = (state_reg.count == UDC_ZERO);

  // terminal count gated by trickle enable only, not the parallel one
  // R12: terminal count low
  // R13: trickle gating
  // R14: no parallel dependence
  // R19: one-state pulse
  assign terminal_count_n = ~(~trickle_count_enable_n
                              & (count_up ? tc_up_hit : tc_down_hit));

  // bus handshakes
  assign s_axi_awready = ~state_reg.aw_hold & ~state_reg.bvalid;
  assign s_axi_wready = ~state_reg.w_hold & ~state_reg.bvalid;
  assign s_axi_arready = ~state_reg.rvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign wr_ctrl = state_reg.aw_hold & state_reg.w_hold
                   & ~state_reg.bvalid
                   & (state_reg.aw_addr == UDC_CTRL_OFS);

  // outputs straight from state flops
  assign count_value = state_reg.count;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;

  // next state of counter and bus slave
  always_comb
  begin
    state_next = state_reg;
    // R7: load wins
    // R5: load copies
    // R6: enables ignored
    // R4: any preset
    if (!load_enable_n)
    begin
      state_next.count = preset_value;
    end
    else if (run_now)
    begin
      if (count_up)
      begin
        // R10: increment
        // R2: binary wraps
        // R18: unused up to zero
        if (DECADE && state_reg.count >= UDC_DECADE_TOP)
        begin
          state_next.count = UDC_ZERO;
        end
        else
        begin
          state_next.count = state_reg.count + 4'h1;
        end
      end
      else
      begin
        // R11: decrement
        // R18: unused down to nine
        if (DECADE && (state_reg.count == UDC_ZERO
                       || state_reg.count > UDC_DECADE_TOP))
        begin
          state_next.count = UDC_DECADE_TOP;
        end
        else
        begin
          state_next.count = state_reg.count - 4'h1;
        end
      end
    end
    // write channel capture, address and data in either order
    if (aw_take)
    begin
      state_next.aw_hold = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (w_take)
    begin
      state_next.w_hold = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    // perform the write once both halves are held
    if (state_reg.aw_hold && state_reg.w_hold && !state_reg.bvalid)
    begin
      state_next.aw_hold = 1'b0;
      state_next.w_hold = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = UDC_RESP_OKAY;
      if (wr_ctrl)
      begin
        if (state_reg.w_strb[0])
        begin
          state_next.run = state_reg.w_data[UDC_CTRL_RUN_BIT];
        end
      end
      else if (state_reg.aw_addr != UDC_STATUS_OFS)
      begin
        state_next.bresp = UDC_RESP_SLVERR;
      end
    end
    if (state_reg.bvalid && s_axi_bready)
    begin
      state_next.bvalid = 1'b0;
    end
    // read answer captured at the address handshake
    if (ar_take)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata = UDC_WORD_RST;
      state_next.rresp = UDC_RESP_OKAY;
      if (s_axi_araddr == UDC_CTRL_OFS)
      begin
        state_next.rdata[UDC_CTRL_RUN_BIT] = state_reg.run;
      end
      else if (s_axi_araddr == UDC_STATUS_OFS)
      begin
        state_next.rdata[UDC_STAT_COUNT_LSB +: 4] = state_reg.count;
        state_next.rdata[UDC_STAT_TC_BIT] = terminal_count_n;
        state_next.rdata[UDC_STAT_UP_BIT] = count_up;
        state_next.rdata[UDC_STAT_RUN_BIT] = state_reg.run;
        state_next.rdata[UDC_STAT_DECADE_BIT] = DECADE;
      end
      else
      begin
        state_next.rresp = UDC_RESP_SLVERR;
      end
    end
    else if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
    end
  end

  // state register, rising edge only, synchronous reset
  // R3: rising edge
  // R1: counter flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
      state_reg.count <= UDC_COUNT_RST;
      state_reg.run <= UDC_CTRL_RUN_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // steps of an enabled count
  sequence s_step;
    run_now;
  endsequence

  sequence s_illegal_step;
    (state_reg.count > UDC_DECADE_TOP) && run_now;
  endsequence

  a_load_copies_preset: assert property ( // R5
    !load_enable_n |=> count_value == $past(preset_value))
    else $error("load did not copy preset value");

  a_load_over_count: assert property ( // R7
    (!load_enable_n && !parallel_count_enable_n
     && !trickle_count_enable_n) |=> count_value == $past(preset_value))
    else $error("count overrode load");

  a_hold_when_off: assert property ( // R9
    (load_enable_n && (parallel_count_enable_n || trickle_count_enable_n))
    |=> $stable(count_value))
    else $error("counter moved while an enable was high");

  a_count_up_step: assert property ( // R10
    (s_step and (count_up && count_value < UDC_DECADE_TOP))
    |=> count_value == $past(count_value) + 4'h1)
    else $error("up count step wrong");

  a_count_down_step: assert property ( // R11
    (s_step and (!count_up && count_value != UDC_ZERO
                 && count_value <= UDC_DECADE_TOP))
    |=> count_value == $past(count_value) - 4'h1)
    else $error("down count step wrong");

  a_up_wrap_zero: assert property ( // R2
    (s_step and (count_up && count_value ==
                 (DECADE ? UDC_DECADE_TOP : UDC_BINARY_TOP)))
    |=> count_value == UDC_ZERO)
    else $error("up count did not wrap to zero");

  a_tc_forced_high: assert property ( // R13
    trickle_count_enable_n |-> terminal_count_n)
    else $error("terminal count low with trickle enable high");

  a_tc_at_top: assert property ( // R12
    (!trickle_count_enable_n && count_up
     && count_value == (DECADE ? UDC_DECADE_TOP : UDC_BINARY_TOP))
    |-> !terminal_count_n)
    else $error("terminal count missed at top");

  a_tc_mid_high: assert property ( // R12
    (count_value == 4'h5) |-> terminal_count_n)
    else $error("terminal count low in a middle state");

  a_illegal_return: assert property ( // R18
    (DECADE && 1'b1) ##0 s_illegal_step ##1 s_step
    |=> count_value <= UDC_DECADE_TOP)
    else $error("decade counter stuck in unused states");

  a_bresp_holds: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped before bready");

endmodule

// ---- hw/udc_pkg.sv ----
// package for the up/down synchronous counter block
// assumes one aclk domain and an axi4-lite register port
package udc_pkg;

  // counter geometry and wrap points
  localparam int UDC_COUNT_W = 4;
  localparam logic [3:0] UDC_ZERO = 4'h0;
  localparam logic [3:0] UDC_DECADE_TOP = 4'h9;
  localparam logic [3:0] UDC_BINARY_TOP = 4'hf;

  // register byte offsets
  localparam logic [31:0] UDC_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] UDC_STATUS_OFS = 32'h0000_0004;

  // control register fields and reset value
  localparam int UDC_CTRL_RUN_BIT = 0;
  localparam logic UDC_CTRL_RUN_RST = 1'b1;

  // status register fields
  localparam int UDC_STAT_COUNT_LSB = 0;
  localparam int UDC_STAT_TC_BIT = 4;
  localparam int UDC_STAT_UP_BIT = 5;
  localparam int UDC_STAT_RUN_BIT = 6;
  localparam int UDC_STAT_DECADE_BIT = 8;

  // reset values of the counter and bus state
  localparam logic [3:0] UDC_COUNT_RST = 4'h0;
  localparam logic [31:0] UDC_WORD_RST = 32'h0000_0000;

  // axi response codes
  localparam logic [1:0] UDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] UDC_RESP_SLVERR = 2'h2;

  // whole state of the block
  typedef struct packed {
    logic [3:0] count;
    logic run;
    logic aw_hold;
    logic [31:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } udc_state_s;

endpackage

// ---- verification/udc_cascade_stage.sv ----
// model of the next cascaded decade stage driven by terminal count
// assumes the carry input is synchronous to aclk
`timescale 1ns/1ps

module udc_cascade_stage
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // carry from the lower stage
  input wire logic carry_n,
  input wire logic count_up,
  // upper digit
  output logic [3:0] digit
);
  // carry enables the step, never clocks it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      digit <= 4'h0;
    else if (!carry_n)
      digit <= count_up ? ((digit == 4'h9) ? 4'h0 : digit + 4'h1)
        : ((digit == 4'h0) ? 4'h9 : digit - 4'h1);
  end
endmodule

// ---- verification/up_down_sync_counter_bench.sv ----
// self-checking bench for the up/down counter, decade build
// assumes the counter and the cascade stage model compile before it
`timescale 1ns/1ps

module up_down_sync_counter_bench;
  import udc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tc_n;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic ld_n = 1'b1, cep_n = 1'b1, cet_n = 1'b0, up = 1'b0;
  logic [3:0] d = 4'h0, m = 4'h0, cnt;
  logic run = 1'b1, chk = 1'b0, chk_d = 1'b0;
  logic [33:0] cq[$], bq[$], rq[$];
  int miscompares = 0, checks_done = 0, cyc = 0;

  // clock at 250 mhz
  always #2 aclk = ~aclk;

  udc_counter #(.DECADE(1'b1)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .load_enable_n(ld_n), .parallel_count_enable_n(cep_n),
    .trickle_count_enable_n(cet_n), .count_up(up),
    .preset_value(d), .count_value(cnt), .terminal_count_n(tc_n));

  udc_cascade_stage next_stage (
    .aclk(aclk), .aresetn(aresetn), .carry_n(tc_n), .count_up(up),
    .digit());

  // compare one value and count it
  task automatic cmp(input string n, input logic [33:0] e, s);
    checks_done++;
    if (e !== s)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // expected terminal count from a count and the live controls
  function automatic logic tc_of(input logic [3:0] c);
    return cet_n | (up ? !(c[0] & c[3]) : (c != 4'h0));
  endfunction

  // expected status word with an okay response
  function automatic logic [33:0] stat();
    return {UDC_RESP_OKAY, 23'h0, 1'b1, 1'b0, run, up, tc_of(m), m};
  endfunction

  // drive one set of controls and note the count expected after the edge
  task automatic step(input logic l, p, t, u, input logic [3:0] v);
    @(posedge aclk);
    ld_n <= l;
    cep_n <= p;
    cet_n <= t;
    up <= u;
    d <= v;
    chk <= 1'b1;
    if (!l)
      m = v;
    else if (!p && !t && run)
      m = u ? ((m >= 4'h9) ? 4'h0 : m + 4'h1)
        : ((m == 4'h0 || m > 4'h9) ? 4'h9 : m - 4'h1);
    cq.push_back({30'h0, m});
  endtask

  // random controls, a load one step in eight
  task automatic rstep(input int n);
    repeat (n)
      step($urandom % 8 != 0, $urandom % 4 == 0, $urandom % 4 == 0,
        $urandom % 2 == 1, 4'($urandom));
  endtask

  // park the controls on hold and stop noting results
  task automatic hold();
    @(posedge aclk);
    chk <= 1'b0;
    cep_n <= 1'b1;
  endtask

  // one axi4-lite write, response noted for the watcher
  task automatic axi_wr(input logic [31:0] a, w, input logic [1:0] r);
    logic ta, tw, bd;
    bq.push_back({32'h0, r});
    @(posedge aclk);
    awaddr <= a;
    wdata <= w;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      bd = bvalid;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end while (!bd);
    bready <= 1'b0;
  endtask

  // one axi4-lite read, response and data noted for the watcher
  task automatic axi_rd(input logic [31:0] a, input logic [33:0] e);
    logic ta, rd;
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = arready;
      rd = rvalid;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
    end while (!rd);
    rready <= 1'b0;
  endtask

  // watcher: take the oldest note when a result appears
  always @(posedge aclk)
    chk_d <= chk;
  always @(negedge aclk)
  begin
    if (chk_d)
    begin
      cmp("count", cq[0], {30'h0, cnt});
      cmp("tc", {33'h0, tc_of(cq[0][3:0])}, {33'h0, tc_n});
      void'(cq.pop_front());
    end
    if (bvalid && bready)
      cmp("bresp", bq.pop_front(), {32'h0, bresp});
    if (rvalid && rready)
      cmp("rdata", rq.pop_front(), {rresp, rdata});
  end

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // cut a hang short
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      miscompares++;
      final_report();
    end
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h223d18fd));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(UDC_CTRL_OFS, {UDC_RESP_OKAY, 31'h0, UDC_CTRL_RUN_RST});
    axi_rd(UDC_STATUS_OFS, stat());
    rstep(400);
    hold();
    // counting stopped by software, loads still land
    axi_wr(UDC_CTRL_OFS, 32'h0, UDC_RESP_OKAY);
    run = 1'b0;
    rstep(30);
    hold();
    axi_wr(UDC_CTRL_OFS, 32'h1, UDC_RESP_OKAY);
    run = 1'b1;
    axi_rd(UDC_CTRL_OFS, {UDC_RESP_OKAY, 32'h1});
    // unmapped and read-only places
    axi_wr(32'h8, 32'hffff_ffff, UDC_RESP_SLVERR);
    axi_rd(32'h8, {UDC_RESP_SLVERR, 32'h0});
    axi_wr(UDC_STATUS_OFS, 32'h0, UDC_RESP_OKAY);
    axi_rd(UDC_STATUS_OFS, stat());
    // second reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    m = UDC_COUNT_RST;
    rstep(100);
    hold();
    final_report();
  end
endmodule
